/* hw/dacsc_pkg.sv */
// Constants and types of the serial command front end of the twelve-channel DAC
package dacsc_pkg;
  localparam int CHANNELS = 12;
  localparam int LEVEL_W = 8;
  localparam int CHAN_W = 4;
  localparam int ROM_ADDRS = 4;
  localparam int CS_FRAME_W = 16;
  localparam int LD_FRAME_W = 14;
  localparam int CS_LEVEL_LSB = 0;
  localparam int CS_CHAN_LSB = 8;
  localparam int CS_PROG_BIT = 12;
  localparam int CS_RECALL_BIT = 13;
  localparam int CS_ADDR_LSB = 14;
  localparam int LD_LEVEL_LSB = 0;
  localparam int LD_CHAN_LSB = 8;
  localparam int LD_PROG_BIT = 12;
  localparam int LD_RECALL_BIT = 13;
  localparam int LD_READ_LSB = 6;
  localparam logic [3:0] CHAN_ALL = 4'h0;
  localparam logic [3:0] CHAN_OFF = 4'hf;
  localparam logic [3:0] CHAN_FIRST = 4'h1;
  localparam logic [3:0] CHAN_LAST = 4'hc;
  localparam logic [3:0] SEQ_LAST_IDX = 4'hb;
  localparam logic PROG_EN_RESET = 1'b0;
  localparam logic [15:0] SHIFT_RESET = 16'h0000;
  localparam logic [7:0] LEVEL_RESET = 8'h00;
  localparam int CLK_MHZ = 125;
  localparam int WRITE_TIME_US = 4;
  localparam int WRITE_CYCLES = WRITE_TIME_US * CLK_MHZ;
  localparam int PIN_COUNT = 7;
  localparam int PIN_SCLK = 0;
  localparam int PIN_DIN = 1;
  localparam int PIN_STROBE = 2;
  localparam int PIN_FMT = 3;
  localparam int PIN_ADDR_LO = 4;
  localparam int PIN_ADDR_HI = 5;
  localparam int PIN_AUTO = 6;
  localparam logic [6:0] PIN_RESET = 7'h04;

  typedef struct packed {
    logic recall;
    logic prog_flag;
    logic [1:0] addr;
    logic [3:0] chan;
    logic [7:0] level;
  } dacsc_frame_type;

  typedef enum logic {SEQ_IDLE, SEQ_ALL} dacsc_state_type;
endpackage

/* hw/dacsc_store.sv */
// Nonvolatile settings store: four addresses of twelve channel levels
`timescale 1ns/1ns
module dacsc_store
  import dacsc_pkg::*;
#(
  parameter int ADDRS = ROM_ADDRS,
  parameter int CHANS = CHANNELS
) (
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [1:0] wr_addr,
  input wire logic [3:0] wr_chan,
  input wire logic [7:0] wr_data,
  input wire logic [1:0] rd_addr,
  input wire logic [3:0] rd_chan,
  output logic [7:0] rd_data
);
  logic [7:0] mem [0:ADDRS*CHANS-1];

  function automatic int slot(input logic [1:0] a, input logic [3:0] c);
    slot = int'(a) * CHANS + int'(c);
  endfunction

  // Contents survive reset, as a nonvolatile array does
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[slot(wr_addr, wr_chan)] <= wr_data;
    end
  end

  assign rd_data = mem[slot(rd_addr, rd_chan)];
endmodule

/* hw/dacsc_sync.sv */
// Two-stage synchroniser for the asynchronous pins
`timescale 1ns/1ns
module dacsc_sync
  import dacsc_pkg::*;
#(
  parameter int WIDTH = PIN_COUNT,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] stage;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      stage <= RESET_VAL;
      dout <= RESET_VAL;
    end else begin
      stage <= din;
      dout <= stage;
    end
  end
endmodule

/* hw/dacsc_top.sv */
// Serial command front end of the twelve-channel DAC with settings store
//
// Functional notes
// - High format: 16-bit register, LSB first
// - Low format: 14-bit register, MSB first
// - Sample serial input on shift clock rise
// - Chip-select format: LSB out, float when deselected
// - Load format: MSB out, status during write
// - Strobe falls, clock high: frame input
// - Strobe falls, clock low: status mode
// - Strobe rise leaves status mode
// - Load pulse executes the shifted frame
// - Load format takes address from pins
// - Auto-load pulse reloads channels one to twelve
// - Frame: flags, address, channel, level
// - Codes one to twelve select outputs
// - Codes zero, fifteen: command meaning elsewhere
// - Flags 00 load level directly
// - Recall one channel from store
// - Recall all channels, auto-load sequence
// - Flags 11, channel zero: enable programming
// - Flags 11, channel fifteen: disable programming
// - Power-up and auto-load disable programming
// - Write store only when programming enabled
// - Flags 11, valid channel: read store out
`timescale 1ns/1ns
module dacsc_top
  import dacsc_pkg::*;
#(
  parameter int WRITE_CYCLES_P = WRITE_CYCLES
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic shift_clk,
  input wire logic serial_in,
  input wire logic select_load_strobe,
  input wire logic format_select,
  input wire logic rom_addr_pin_low,
  input wire logic rom_addr_pin_high,
  input wire logic auto_load_pin,
  output logic serial_out,
  output logic serial_out_en,
  output logic [CHANNELS-1:0][LEVEL_W-1:0] dac_level,
  output logic prog_enabled,
  output logic busy
);
  localparam int BUSY_W = $clog2(WRITE_CYCLES_P + 1);
  localparam logic [BUSY_W-1:0] BUSY_LOAD = BUSY_W'(WRITE_CYCLES_P);

  logic [PIN_COUNT-1:0] pins_raw;
  logic [PIN_COUNT-1:0] pins;
  logic sclk_prev;
  logic strobe_prev;
  logic auto_prev;
  logic sclk_rise;
  logic sclk_fall;
  logic strobe_rise;
  logic strobe_fall;
  logic auto_rise;
  logic cs_mode;
  logic frame_open;
  logic status_mode;
  logic write_status;
  logic [CS_FRAME_W-1:0] shift_reg;
  logic [CS_FRAME_W-1:0] next_shift_reg;
  dacsc_frame_type frame;
  logic exec;
  logic chan_valid;
  logic [3:0] ch_idx;
  logic cmd_direct;
  logic cmd_recall_one;
  logic cmd_recall_all;
  logic cmd_wen;
  logic cmd_wdis;
  logic cmd_write;
  logic cmd_read;
  logic read_load;
  dacsc_state_type seq_state;
  logic [3:0] seq_idx;
  logic [1:0] seq_addr;
  logic seq_auto;
  logic seq_done;
  logic [1:0] rd_addr;
  logic [3:0] rd_chan;
  logic [7:0] rd_data;
  logic [7:0] rd_reversed;
  logic [BUSY_W-1:0] busy_count;

  assign pins_raw = {auto_load_pin, rom_addr_pin_high, rom_addr_pin_low, format_select,
                     select_load_strobe, serial_in, shift_clk};

  dacsc_sync #(
    .WIDTH(PIN_COUNT),
    .RESET_VAL(PIN_RESET)
  ) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .din(pins_raw),
    .dout(pins)
  );

  // Edge detection on the synchronised pins
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sclk_prev <= 1'b0;
      strobe_prev <= PIN_RESET[PIN_STROBE];
      auto_prev <= 1'b0;
    end else begin
      sclk_prev <= pins[PIN_SCLK];
      strobe_prev <= pins[PIN_STROBE];
      auto_prev <= pins[PIN_AUTO];
    end
  end

  assign sclk_rise = pins[PIN_SCLK] & ~sclk_prev;
  assign sclk_fall = ~pins[PIN_SCLK] & sclk_prev;
  assign strobe_rise = pins[PIN_STROBE] & ~strobe_prev;
  assign strobe_fall = ~pins[PIN_STROBE] & strobe_prev;
  assign auto_rise = pins[PIN_AUTO] & ~auto_prev;
  assign cs_mode = pins[PIN_FMT];

  // Chip-select framing and status mode
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      frame_open <= 1'b0;
      status_mode <= 1'b0;
    end else if (!cs_mode) begin
      frame_open <= 1'b0;
      status_mode <= 1'b0;
    end else if (strobe_rise) begin
      frame_open <= 1'b0;
      status_mode <= 1'b0;
    end else if (strobe_fall) begin
      frame_open <= pins[PIN_SCLK];
      status_mode <= ~pins[PIN_SCLK];
    end
  end

  always_comb begin
    rd_reversed = {<<{rd_data}};
  end

  always_comb begin
    next_shift_reg = shift_reg;
    if (read_load) begin
      next_shift_reg = cs_mode ? {8'h00, rd_reversed} : (16'(rd_data) << LD_READ_LSB);
    end else if (sclk_rise && (frame_open || !cs_mode)) begin
      if (cs_mode) begin
        next_shift_reg = {pins[PIN_DIN], shift_reg[CS_FRAME_W-1:1]};
      end else begin
        next_shift_reg = {2'b00, shift_reg[LD_FRAME_W-2:0], pins[PIN_DIN]};
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      shift_reg <= SHIFT_RESET;
    end else begin
      shift_reg <= next_shift_reg;
    end
  end

  always_comb begin
    frame.level = shift_reg[CS_LEVEL_LSB +: LEVEL_W];
    frame.chan = shift_reg[CS_CHAN_LSB +: CHAN_W];
    frame.prog_flag = shift_reg[CS_PROG_BIT];
    frame.recall = shift_reg[CS_RECALL_BIT];
    frame.addr = shift_reg[CS_ADDR_LSB +: 2];
    if (!cs_mode) begin
      frame.level = shift_reg[LD_LEVEL_LSB +: LEVEL_W];
      frame.chan = shift_reg[LD_CHAN_LSB +: CHAN_W];
      frame.prog_flag = shift_reg[LD_PROG_BIT];
      frame.recall = shift_reg[LD_RECALL_BIT];
      frame.addr = {pins[PIN_ADDR_HI], pins[PIN_ADDR_LO]};
    end
  end

  assign exec = strobe_rise & (frame_open | ~cs_mode);
  assign chan_valid = (frame.chan >= CHAN_FIRST) && (frame.chan <= CHAN_LAST);
  assign ch_idx = frame.chan - CHAN_FIRST;

  assign cmd_direct = exec & ~frame.recall & ~frame.prog_flag & chan_valid;
  assign cmd_recall_one = exec & frame.recall & ~frame.prog_flag & chan_valid
                          & (seq_state == SEQ_IDLE);
  assign cmd_recall_all = exec & frame.recall & ~frame.prog_flag & (frame.chan == CHAN_ALL);
  assign cmd_wen = exec & frame.recall & frame.prog_flag & (frame.chan == CHAN_ALL);
  assign cmd_wdis = exec & frame.recall & frame.prog_flag & (frame.chan == CHAN_OFF);
  assign cmd_write = exec & ~frame.recall & frame.prog_flag & chan_valid & prog_enabled & ~busy;
  assign cmd_read = exec & frame.recall & frame.prog_flag & chan_valid;
  assign read_load = cmd_read & (seq_state == SEQ_IDLE);
  assign seq_done = (seq_state == SEQ_ALL) && (seq_idx == SEQ_LAST_IDX);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      seq_state <= SEQ_IDLE;
      seq_idx <= 4'h0;
      seq_addr <= 2'b00;
      seq_auto <= 1'b0;
    end else begin
      unique case (seq_state)
        SEQ_IDLE: begin
          seq_idx <= 4'h0;
          if (auto_rise) begin
            seq_state <= SEQ_ALL;
            seq_addr <= {pins[PIN_ADDR_HI], pins[PIN_ADDR_LO]};
            seq_auto <= 1'b1;
          end else if (cmd_recall_all) begin
            seq_state <= SEQ_ALL;
            seq_addr <= frame.addr;
            seq_auto <= 1'b0;
          end
        end
        SEQ_ALL: begin
          if (seq_done) begin
            seq_state <= SEQ_IDLE;
          end else begin
            seq_idx <= seq_idx + 4'h1;
          end
        end
      endcase
    end
  end

  assign rd_addr = (seq_state == SEQ_ALL) ? seq_addr : frame.addr;
  assign rd_chan = (seq_state == SEQ_ALL) ? seq_idx : ch_idx;

  dacsc_store #(
    .ADDRS(ROM_ADDRS),
    .CHANS(CHANNELS)
  ) u_store (
    .clk(clk),
    .wr_en(cmd_write),
    .wr_addr(frame.addr),
    .wr_chan(ch_idx),
    .wr_data(frame.level),
    .rd_addr(rd_addr),
    .rd_chan(rd_chan),
    .rd_data(rd_data)
  );

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dac_level <= {CHANNELS{LEVEL_RESET}};
    end else if (seq_state == SEQ_ALL) begin
      dac_level[seq_idx] <= rd_data;
    end else if (cmd_direct) begin
      dac_level[ch_idx] <= frame.level;
    end else if (cmd_recall_one) begin
      dac_level[ch_idx] <= rd_data;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prog_enabled <= PROG_EN_RESET;
    end else if (seq_done && seq_auto) begin
      prog_enabled <= 1'b0;
    end else if (cmd_wen) begin
      prog_enabled <= 1'b1;
    end else if (cmd_wdis) begin
      prog_enabled <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      busy_count <= '0;
      busy <= 1'b0;
    end else if (cmd_write) begin
      busy_count <= BUSY_LOAD;
      busy <= 1'b1;
    end else if (busy_count != '0) begin
      busy_count <= busy_count - 1'b1;
      busy <= (busy_count != BUSY_W'(1));
    end
  end

  // Load-format status window after a write command
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      write_status <= 1'b0;
    end else if (cmd_write && !cs_mode) begin
      write_status <= 1'b1;
    end else if (sclk_fall || strobe_rise) begin
      write_status <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      serial_out <= 1'b0;
      serial_out_en <= 1'b0;
    end else if (cs_mode) begin
      serial_out_en <= ~pins[PIN_STROBE];
      if (status_mode) begin
        serial_out <= ~busy;
      end else if (sclk_fall) begin
        serial_out <= shift_reg[0];
      end
    end else begin
      serial_out_en <= 1'b1;
      if (write_status) begin
        serial_out <= ~busy;
      end else if (read_load) begin
        serial_out <= rd_data[LEVEL_W-1];
      end else if (sclk_fall) begin
        serial_out <= shift_reg[LD_FRAME_W-1];
      end
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  property p_cs_shift;
    cs_mode && frame_open && sclk_rise && !read_load |=> shift_reg[15] == $past(pins[PIN_DIN]);
  endproperty
  a_cs_shift: assert property (p_cs_shift) else $error("Chip-select bit not shifted in");

  property p_ld_shift;
    !cs_mode && sclk_rise && !read_load |=> shift_reg[0] == $past(pins[PIN_DIN]);
  endproperty
  a_ld_shift: assert property (p_ld_shift) else $error("Load-format bit not shifted in");

  property p_float;
    cs_mode && pins[PIN_STROBE] |=> !serial_out_en;
  endproperty
  a_float: assert property (p_float) else $error("Output driven while deselected");

  property p_status;
    cs_mode && status_mode && !strobe_rise |=> serial_out == !$past(busy);
  endproperty
  a_status: assert property (p_status) else $error("Status mode shows wrong ready");

  property p_direct;
    cmd_direct && seq_state == SEQ_IDLE |=> dac_level[$past(ch_idx)] == $past(frame.level);
  endproperty
  a_direct: assert property (p_direct) else $error("Direct level not loaded");

  property p_auto_seq;
    auto_rise && seq_state == SEQ_IDLE
      |=> seq_state == SEQ_ALL && seq_idx == 4'h0 ##11 seq_idx == SEQ_LAST_IDX
      ##1 seq_state == SEQ_IDLE && !prog_enabled;
  endproperty
  a_auto_seq: assert property (p_auto_seq) else $error("Auto-load sequence wrong");

  property p_enable;
    cmd_wen && !(seq_done && seq_auto) |=> prog_enabled;
  endproperty
  a_enable: assert property (p_enable) else $error("Programming not enabled");

  property p_disable;
    cmd_wdis |=> !prog_enabled;
  endproperty
  a_disable: assert property (p_disable) else $error("Programming not disabled");

  property p_busy;
    cmd_write |=> busy [*8];
  endproperty
  a_busy: assert property (p_busy) else $error("Busy window too short");

  property p_unusable;
    exec && frame.chan > CHAN_LAST && frame.chan < CHAN_OFF && seq_state == SEQ_IDLE
      && !auto_rise |=> dac_level == $past(dac_level) && ($past(busy) || !busy);
  endproperty
  a_unusable: assert property (p_unusable) else $error("Unusable code changed state");
endmodule

/* verification/dacsc_host.sv */
// Host model driving the serial command pins of the DAC front end
`timescale 1ns/1ns
module dacsc_host (
  input wire logic clk,
  input wire logic serial_out,
  output logic shift_clk,
  output logic serial_in,
  output logic select_load_strobe
);
  logic [15:0] rx_lsb;
  logic [15:0] rx_msb;

  initial begin
    shift_clk = 1'b0;
    serial_in = 1'b0;
    select_load_strobe = 1'b1;
    rx_lsb = 16'h0000;
    rx_msb = 16'h0000;
  end

  // Half a shift clock period, 32 ns of a 64 ns period
  task automatic half();
    repeat (4) @(posedge clk);
  endtask

  task automatic bit_out(input logic b);
    shift_clk <= 1'b0;
    serial_in <= b;
    half();
    rx_lsb <= {serial_out, rx_lsb[15:1]};
    rx_msb <= {rx_msb[14:0], serial_out};
    shift_clk <= 1'b1;
    half();
  endtask

  task automatic set_strobe(input logic v);
    select_load_strobe <= v;
    half();
  endtask

  task automatic cs_frame(input logic [15:0] f);
    shift_clk <= 1'b1;
    half();
    select_load_strobe <= 1'b0;
    half();
    for (int i = 0; i < 16; i++) begin
      bit_out(f[i]);
    end
    select_load_strobe <= 1'b1;
    serial_in <= ~serial_in;
    half();
  endtask

  task automatic ld_frame(input logic [13:0] f);
    for (int i = 13; i >= 0; i--) begin
      bit_out(f[i]);
    end
    shift_clk <= 1'b0;
    serial_in <= ~serial_in;
    half();
    select_load_strobe <= 1'b1;
    half();
    select_load_strobe <= 1'b0;
    half();
  endtask

  task automatic status_open();
    shift_clk <= 1'b0;
    half();
    select_load_strobe <= 1'b0;
    half();
  endtask
endmodule

/* verification/tb_dac_eeprom_serial_control.sv */
// Self-checking bench of the DAC serial command front end
`timescale 1ns/1ns
module tb_dac_eeprom_serial_control
  import dacsc_pkg::*;
;
  localparam int WCYC = 40;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic format_select = 1'b1;
  logic rom_addr_pin_low = 1'b0;
  logic rom_addr_pin_high = 1'b0;
  logic auto_load_pin = 1'b0;
  logic shift_clk;
  logic serial_in;
  logic select_load_strobe;
  logic serial_out;
  logic serial_out_en;
  logic serial_pin;
  logic [CHANNELS-1:0][LEVEL_W-1:0] dac_level;
  logic prog_enabled;
  logic busy;
  logic [3:0] odd [4] = '{4'hd, 4'he, 4'h0, 4'hf};
  int n_errors = 0;
  int num_checks = 0;

  always #4 clk = ~clk;

  // Released output reads as the inverse, no pull on this pin
  assign serial_pin = serial_out_en ? serial_out : ~serial_out;

  dacsc_top #(.WRITE_CYCLES_P(WCYC)) dut_u (
    .clk(clk), .sys_rst(sys_rst), .shift_clk(shift_clk), .serial_in(serial_in),
    .select_load_strobe(select_load_strobe), .format_select(format_select),
    .rom_addr_pin_low(rom_addr_pin_low), .rom_addr_pin_high(rom_addr_pin_high),
    .auto_load_pin(auto_load_pin), .serial_out(serial_out), .serial_out_en(serial_out_en),
    .dac_level(dac_level), .prog_enabled(prog_enabled), .busy(busy)
  );

  dacsc_host host_u (
    .clk(clk), .serial_out(serial_pin), .shift_clk(shift_clk), .serial_in(serial_in),
    .select_load_strobe(select_load_strobe)
  );

  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic fail(input string msg);
    n_errors++;
    $display("ERROR at %0t: %s", $time, msg);
  endtask

  task automatic chk_lvl(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) fail($sformatf("level %h, expected %h", got, exp));
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) fail($sformatf("flag %b, expected %b", got, exp));
  endtask

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) fail($sformatf("shifted %h, expected %h", got, exp));
  endtask

  function automatic logic [15:0] cs(input logic [1:0] a, input logic [1:0] fl,
      input logic [3:0] ch, input logic [7:0] lv);
    return {a, fl, ch, lv};
  endfunction

  function automatic logic [13:0] ld(input logic [1:0] fl, input logic [3:0] ch,
      input logic [7:0] lv);
    return {fl, ch, lv};
  endfunction

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic power_up(input logic fmt);
    sys_rst <= 1'b1;
    format_select <= fmt;
    host_u.set_strobe(fmt);
    settle(2);
    sys_rst <= 1'b0;
    settle(6);
  endtask

  task automatic pins(input logic [1:0] a);
    rom_addr_pin_high <= a[1];
    rom_addr_pin_low <= a[0];
    settle(4);
  endtask

  task automatic wait_ready();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 200) begin
      @(posedge clk);
      n++;
    end
    if (n >= 200) begin
      fail("busy never cleared");
      wrap_up();
    end
  endtask

  initial begin
    power_up(1'b1);
    chk_bit(prog_enabled, PROG_EN_RESET);
    chk_bit(serial_out_en, 1'b0);
    host_u.cs_frame(cs(2'h1, 2'b00, 4'h1, 8'ha5));
    settle(8);
    chk_lvl(dac_level[0], 8'ha5);
    host_u.cs_frame(cs(2'h0, 2'b00, 4'hc, 8'h3c));
    settle(8);
    chk_word(host_u.rx_lsb, cs(2'h1, 2'b00, 4'h1, 8'ha5));
    chk_lvl(dac_level[11], 8'h3c);
    for (int i = 0; i < 4; i++) begin
      host_u.cs_frame(cs(2'h0, 2'b00, odd[i], 8'hff));
      settle(8);
      chk_lvl(dac_level[0], 8'ha5);
      chk_lvl(dac_level[11], 8'h3c);
    end
    $display("test direct done");
    host_u.status_open();
    settle(4);
    chk_bit(serial_out_en, 1'b1);
    chk_bit(serial_out, 1'b1);
    host_u.set_strobe(1'b1);
    settle(4);
    chk_bit(serial_out_en, 1'b0);
    host_u.cs_frame(cs(2'h3, 2'b11, 4'h0, 8'h5a));
    settle(4);
    chk_bit(prog_enabled, 1'b1);
    host_u.cs_frame(cs(2'h2, 2'b01, 4'h3, 8'h77));
    settle(4);
    chk_bit(busy, 1'b1);
    host_u.status_open();
    settle(4);
    chk_bit(serial_out, 1'b0);
    host_u.set_strobe(1'b1);
    wait_ready();
    host_u.cs_frame(cs(2'h2, 2'b01, 4'h5, 8'h11));
    settle(4);
    wait_ready();
    host_u.cs_frame(cs(2'h1, 2'b11, 4'hf, 8'h5a));
    settle(4);
    chk_bit(prog_enabled, 1'b0);
    host_u.cs_frame(cs(2'h2, 2'b01, 4'h3, 8'h99));
    settle(4);
    chk_bit(busy, 1'b0);
    host_u.cs_frame(cs(2'h2, 2'b10, 4'h3, 8'hee));
    settle(8);
    chk_lvl(dac_level[2], 8'h77);
    host_u.cs_frame(cs(2'h2, 2'b11, 4'h3, 8'h00));
    host_u.cs_frame(cs(2'h0, 2'b00, 4'h0, 8'h00));
    chk_lvl(host_u.rx_msb[15:8], 8'h77);
    $display("test store done");
    host_u.cs_frame(cs(2'h0, 2'b00, 4'h3, 8'h00));
    host_u.cs_frame(cs(2'h0, 2'b00, 4'h5, 8'h00));
    host_u.cs_frame(cs(2'h2, 2'b10, 4'h0, 8'h00));
    settle(20);
    chk_lvl(dac_level[2], 8'h77);
    chk_lvl(dac_level[4], 8'h11);
    host_u.cs_frame(cs(2'h0, 2'b00, 4'h3, 8'h00));
    host_u.cs_frame(cs(2'h0, 2'b11, 4'h0, 8'h00));
    pins(2'b10);
    auto_load_pin <= 1'b1;
    settle(4);
    auto_load_pin <= 1'b0;
    settle(24);
    chk_lvl(dac_level[2], 8'h77);
    chk_bit(prog_enabled, 1'b0);
    $display("test recall done");
    power_up(1'b0);
    host_u.ld_frame(ld(2'b00, 4'h7, 8'h5a));
    settle(8);
    chk_lvl(dac_level[6], 8'h5a);
    host_u.ld_frame(ld(2'b10, 4'h3, 8'h00));
    settle(8);
    chk_word({2'b00, host_u.rx_msb[13:0]}, {2'b00, ld(2'b00, 4'h7, 8'h5a)});
    chk_lvl(dac_level[2], 8'h77);
    host_u.ld_frame(ld(2'b11, 4'h0, 8'h00));
    pins(2'b01);
    host_u.ld_frame(ld(2'b01, 4'h3, 8'hc3));
    settle(4);
    chk_bit(serial_out, 1'b0);
    wait_ready();
    host_u.ld_frame(ld(2'b10, 4'h3, 8'h00));
    settle(8);
    chk_lvl(dac_level[2], 8'hc3);
    host_u.ld_frame(ld(2'b11, 4'h3, 8'h00));
    host_u.ld_frame(ld(2'b00, 4'h0, 8'h00));
    chk_lvl(host_u.rx_msb[13:6], 8'hc3);
    $display("test load format done");
    wrap_up();
  end
endmodule
